// >>> rtl/sbr_consts.vh
// Constants of the split bus address router
`ifndef SBR_CONSTS_VH
`define SBR_CONSTS_VH
// Region boundaries
`define SBR_SDRAM_LO 32'h4000_0000
`define SBR_SRAM_LO 32'h8000_0000
`define SBR_RSV1_LO 32'h9000_0000
`define SBR_EXT2_LO 32'hC000_0000
`define SBR_RSV2_LO 32'hE000_0000
`define SBR_PERIPH_LO 32'hF000_0000
// Fixed module register base inside peripheral space
`define SBR_MODREG_BASE 32'hFC00_0000
// Slave indices
`define SBR_S_EXT 0
`define SBR_S_SDRAM 1
`define SBR_S_SRAM 2
`define SBR_S_PERIPH 3
// External port size codes
`define SBR_PS_32 2'h0
`define SBR_PS_8 2'h1
`define SBR_PS_16 2'h2
// Strap level meaning split mode
`define SBR_STRAP_SPLIT 1'h1
// Reset values
`define SBR_MODE_RST 1'h0
`define SBR_GRANT_RST 3'h0
`endif

// >>> rtl/sbr_arb.v
// Per-slave arbiter of the crossbar: fixed or round-robin priority
`timescale 1ns/10ps
`include "sbr_consts.vh"
module sbr_arb
#(
   parameter N = 3
)
(
   input wire clk,
   input wire rst_n,
   input wire [N-1:0] req,
   input wire done,
   input wire rr_mode,
   output reg [N-1:0] grant_r
);
   reg [N-1:0] pick;
   reg [1:0] last_r;
   reg found;
   integer k;
   integer idx;
   integer q;

   // Lowest index wins in fixed mode; search starts after last owner in round robin
   always @*
   begin
      pick = {N{1'b0}};
      found = 1'b0;
      idx = 0;
      for (k = 0; k < N; k = k + 1)
      begin
         idx = rr_mode ? ((last_r + 1 + k) % N) : k;
         if (!found && req[idx])
         begin
            pick[idx] = 1'b1;
            found = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         grant_r <= `SBR_GRANT_RST;
         last_r <= 2'h0;
      end
      else if (done)
         grant_r <= {N{1'b0}};
      else if ((grant_r & req) == {N{1'b0}})
      begin
         grant_r <= pick;
         for (q = 0; q < N; q = q + 1)
         begin
            if (pick[q])
               last_r <= q[1:0];
         end
      end
   end
endmodule

// >>> rtl/sbr_router.v
// Split bus address router: strap mode latch, address decode and crossbar
`timescale 1ns/10ps
`include "sbr_consts.vh"
module sbr_router
(
   input wire clk,
   input wire rst_b,
   input wire bus_split_strap,
   // Masters, three, packed lowest master in lowest bits
   input wire [2:0] m_req,
   input wire [95:0] m_addr,
   input wire [2:0] m_we,
   input wire [95:0] m_wdata,
   output reg [2:0] m_ack_r,
   output reg [2:0] m_err_r,
   output reg [95:0] m_rdata_r,
   // Per-slave arbitration method, 1 = round robin
   input wire [3:0] arb_rr,
   // SRAM base, 16 KB granule inside its region
   input wire [13:0] sram_base,
   // Slaves: external bus, sdram controller, sram, peripheral space
   output wire [3:0] s_req,
   output wire [127:0] s_addr,
   output wire [3:0] s_we,
   output wire [127:0] s_wdata,
   input wire [3:0] s_ack,
   input wire [127:0] s_rdata,
   // External bus chip select port size from chip_select_control
   input wire [1:0] cs_port_size,
   output reg [1:0] ext_port_size_eff,
   output wire ext_port_bad,
   output wire split_mode,
   output wire [1:0] ext_lane_en,
   output wire [1:0] sdram_lane_en,
   output wire [31:0] modreg_offset
);
   reg rst_s1_r;
   reg rst_n_r;
   reg strap_s1_r;
   reg strap_s2_r;
   reg mode_r;
   reg latched_r;
   reg [1:0] fill_r;
   reg [3:0] tgt [0:2];
   reg [2:0] rsv;
   reg [11:0] sreq;
   wire [11:0] grant;
   integer i;
   integer s;
   integer j;
   integer mi;
   integer si;

   // Reset release through two flip-flops
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // Strap pin synchroniser
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
      end
      else
      begin
         strap_s1_r <= bus_split_strap;
         strap_s2_r <= strap_s1_r;
      end
   end

   // Mode caught once, after the synchroniser has filled; the reset zeros of
   // the sync flops must never be taken for the strap level
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         mode_r <= `SBR_MODE_RST;
         latched_r <= 1'b0;
         fill_r <= 2'h0;
      end
      else if (!latched_r)
      begin
         fill_r <= {fill_r[0], 1'b1};
         if (fill_r[1])
         begin
            mode_r <= (strap_s2_r == `SBR_STRAP_SPLIT);
            latched_r <= 1'b1;
         end
      end
   end

   assign split_mode = mode_r;

   // Data lane ownership: bit 0 low half, bit 1 high half
   assign ext_lane_en = mode_r ? 2'h1 : 2'h3;
   assign sdram_lane_en = mode_r ? 2'h2 : 2'h3;

   // Port widths allowed per mode; a 32-bit setting in split mode is narrowed
   assign ext_port_bad = mode_r && (cs_port_size == `SBR_PS_32);
   always @*
   begin
      if (ext_port_bad)
         ext_port_size_eff = `SBR_PS_16;
      else
         ext_port_size_eff = cs_port_size;
   end

   // Offset within the fixed module register space
   assign modreg_offset = m_addr[31:0] - `SBR_MODREG_BASE;

   // Address decode per master
   always @*
   begin
      for (i = 0; i < 3; i = i + 1)
      begin
         tgt[i] = 4'h0;
         rsv[i] = 1'b0;
         if (m_addr[i*32 +: 32] < `SBR_SDRAM_LO)
            tgt[i][`SBR_S_EXT] = 1'b1;
         else if (m_addr[i*32 +: 32] < `SBR_SRAM_LO)
            tgt[i][`SBR_S_SDRAM] = 1'b1;
         else if (m_addr[i*32 +: 32] < `SBR_RSV1_LO)
         begin
            if (m_addr[i*32+14 +: 14] == sram_base)
               tgt[i][`SBR_S_SRAM] = 1'b1;
            else
               rsv[i] = 1'b1;
         end
         else if (m_addr[i*32 +: 32] < `SBR_EXT2_LO)
            rsv[i] = 1'b1;
         else if (m_addr[i*32 +: 32] < `SBR_RSV2_LO)
            tgt[i][`SBR_S_EXT] = 1'b1;
         else if (m_addr[i*32 +: 32] < `SBR_PERIPH_LO)
            rsv[i] = 1'b1;
         else
            tgt[i][`SBR_S_PERIPH] = 1'b1;
      end
   end

   // Requests seen by each slave arbiter, masked during the answer cycle
   always @*
   begin
      for (s = 0; s < 4; s = s + 1)
      begin
         for (j = 0; j < 3; j = j + 1)
            sreq[s*3+j] = m_req[j] & tgt[j][s] & ~m_ack_r[j] & ~m_err_r[j];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : slv
         sbr_arb #(.N(3)) u_arb
         (
            .clk(clk),
            .rst_n(rst_n_r),
            .req(sreq[g*3 +: 3]),
            .done(s_ack[g]),
            .rr_mode(arb_rr[g]),
            .grant_r(grant[g*3 +: 3])
         );
         // Each slave port muxes only its own owner
         assign s_req[g] = |(grant[g*3 +: 3] & sreq[g*3 +: 3]);
         assign s_addr[g*32 +: 32] = grant[g*3+2] ? m_addr[64 +: 32] :
                                     grant[g*3+1] ? m_addr[32 +: 32] : m_addr[0 +: 32];
         assign s_wdata[g*32 +: 32] = grant[g*3+2] ? m_wdata[64 +: 32] :
                                      grant[g*3+1] ? m_wdata[32 +: 32] : m_wdata[0 +: 32];
         assign s_we[g] = |(grant[g*3 +: 3] & m_we);
      end
   endgenerate

   // Answers back to masters: ack one cycle after the slave ack, error one cycle after a reserved request
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         m_ack_r <= 3'h0;
         m_err_r <= 3'h0;
         m_rdata_r <= 96'h0;
      end
      else
      begin
         for (mi = 0; mi < 3; mi = mi + 1)
         begin
            m_ack_r[mi] <= 1'b0;
            m_err_r[mi] <= m_req[mi] & rsv[mi] & ~m_err_r[mi];
            for (si = 0; si < 4; si = si + 1)
            begin
               if (s_ack[si] && grant[si*3+mi])
               begin
                  m_ack_r[mi] <= 1'b1;
                  m_rdata_r[mi*32 +: 32] <= s_rdata[si*32 +: 32];
               end
            end
         end
      end
   end
endmodule

// >>> testbench/sbr_router_checker.sv
// Assertion checker of the router ports
`timescale 1ns/10ps
module sbr_router_checker
(
   input wire clk,
   input wire rst_b,
   input wire [2:0] m_req,
   input wire [95:0] m_addr,
   input wire [2:0] m_ack_r,
   input wire [2:0] m_err_r,
   input wire [3:0] s_req,
   input wire [127:0] s_addr,
   input wire [3:0] s_ack,
   input wire [1:0] cs_port_size,
   input wire [1:0] ext_port_size_eff,
   input wire ext_port_bad,
   input wire split_mode,
   input wire [1:0] ext_lane_en,
   input wire [1:0] sdram_lane_en,
   input wire [31:0] modreg_offset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire [3:0] top0 = m_addr[31:28];
   wire rsv0 = top0 == 4'h9 || top0 == 4'hA || top0 == 4'hB || top0 == 4'hE;
   a_shared_lanes: assert property (!split_mode |-> ext_lane_en == 2'h3 && sdram_lane_en == 2'h3)
      else $error("shared lanes wrong");
   a_split_lanes: assert property (split_mode |-> ext_lane_en == 2'h1 && sdram_lane_en == 2'h2)
      else $error("split lanes wrong");
   a_shared_size: assert property (!split_mode |-> ext_port_size_eff == cs_port_size && !ext_port_bad)
      else $error("shared port size altered");
   a_split_size: assert property (split_mode |-> ext_port_bad == (cs_port_size == 2'h0) && ext_port_size_eff != 2'h0)
      else $error("split port size wrong");
   a_mode_held: assert property (split_mode |=> split_mode)
      else $error("latched mode changed");
   a_modreg_fixed: assert property (modreg_offset == m_addr[31:0] - 32'hFC00_0000)
      else $error("register offset wrong");
   a_rsv_error: assert property (m_req[0] && rsv0 && !m_err_r[0] && !m_ack_r[0] |=> m_err_r[0] && !m_ack_r[0])
      else $error("reserved access not refused");
   a_ack_follows: assert property (s_req[2] && s_ack[2] |=> |m_ack_r)
      else $error("slave done not passed on");
   a_periph_range: assert property (s_req[3] |-> s_addr[127:124] == 4'hF)
      else $error("peripheral decode wrong");
   c_split: cover property (split_mode);
   c_error: cover property (m_err_r[0]);
   c_parallel: cover property (s_req[0] && s_req[2]);
endmodule

// >>> testbench/sbr_slave_model.sv
// Responder model of the four slaves behind the router
`timescale 1ns/10ps
module sbr_slave_model
(
   input wire clk,
   input wire [3:0] s_req,
   input wire [127:0] s_addr,
   input wire [3:0] slow,
   output reg [3:0] s_ack = 4'h0,
   output reg [127:0] s_rdata = 128'h0
);
   reg [7:0] cnt = 8'h00;
   integer i;
   // Slow slaves answer on the fourth cycle; data churns outside acks
   always @(posedge clk)
      for (i = 0; i < 4; i = i + 1)
      begin
         s_ack[i] <= 1'b0;
         s_rdata[32*i+:32] <= ~s_rdata[32*i+:32];
         if (s_req[i] && !s_ack[i])
         begin
            cnt[2*i+:2] <= cnt[2*i+:2] + 2'h1;
            if (cnt[2*i+:2] == (slow[i] ? 2'h3 : 2'h0))
            begin
               s_ack[i] <= 1'b1;
               s_rdata[32*i+:32] <= s_addr[32*i+:32] ^ 32'h5A5A_5A5A;
               cnt[2*i+:2] <= 2'h0;
            end
         end
      end
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the router
`timescale 1ns/10ps
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin miscompares = miscompares + 1; \
$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg bus_split_strap = 1'b0;
   reg [2:0] m_req = 3'h0;
   reg [95:0] m_addr = 96'h0;
   reg [3:0] arb_rr = 4'h0;
   reg [13:0] sram_base = 14'h0;
   reg [1:0] cs_port_size = 2'h0;
   reg [3:0] slow = 4'h0;
   reg [11:0] ord = 12'h0;
   reg [2:0] m_we = 3'h0;
   reg [95:0] m_wdata = 96'h0;
   wire [2:0] m_ack_r, m_err_r;
   wire [95:0] m_rdata_r;
   wire [3:0] s_req, s_ack, s_we;
   wire [127:0] s_addr, s_rdata, s_wdata;
   wire [1:0] ext_port_size_eff, ext_lane_en, sdram_lane_en;
   wire ext_port_bad, split_mode;
   wire [31:0] modreg_offset;
   integer miscompares = 0, checked = 0, cyc = 0;
   sbr_router DUT
   (
      .clk, .rst_b, .bus_split_strap, .m_req, .m_addr, .m_we, .m_wdata, .m_ack_r, .m_err_r,
      .m_rdata_r, .arb_rr, .sram_base, .s_req, .s_addr, .s_we, .s_wdata, .s_ack, .s_rdata, .cs_port_size,
      .ext_port_size_eff, .ext_port_bad, .split_mode, .ext_lane_en, .sdram_lane_en, .modreg_offset
   );
   sbr_slave_model SLV (.clk, .s_req, .s_addr, .slow, .s_ack, .s_rdata);
   initial
      forever #10 clk = ~clk;
   task give_verdict;
   begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   task t_mode(input s);
      integer c;
   begin
      rst_b = 1'b0;
      bus_split_strap = s; // split strap stands for a double-rate memory board
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      `CHK(split_mode, s)
      `CHK({ext_lane_en, sdram_lane_en}, s ? 4'h6 : 4'hF)
      for (c = 0; c < 3; c = c + 1)
      begin
         cs_port_size = c[1:0];
         #1;
         `CHK({ext_port_bad, ext_port_size_eff}, (s && c == 0) ? 3'h6 : {1'b0, c[1:0]})
      end
      bus_split_strap = !s;
      repeat (8) @(negedge clk);
      `CHK(split_mode, s)
   end
   endtask
   task automatic xfer(input integer m, input [31:0] a, input [3:0] sl);
      integer n, k;
      reg [3:0] seen;
      reg wbad;
   begin
      seen = 4'h0;
      wbad = 1'b0;
      n = 0;
      @(negedge clk);
      m_addr[32*m+:32] = a;
      m_wdata[32*m+:32] = ~a;
      m_we[m] = a[8];
      m_req[m] = 1'b1;
      while (m_ack_r[m] !== 1'b1 && m_err_r[m] !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n = n + 1;
         for (k = 0; k < 4; k = k + 1)
            if (s_req[k] === 1'b1 && s_addr[32*k+:32] === a)
            begin
               seen[k] = 1'b1;
               if (s_wdata[32*k+:32] !== ~a || s_we[k] !== a[8])
                  wbad = 1'b1;
            end
      end
      ord = {ord[7:0], m[3:0]};
      `CHK(seen, sl)
      `CHK(wbad, 1'b0)
      `CHK(m_err_r[m], sl == 4'h0)
      if (sl != 4'h0)
         `CHK(m_rdata_r[32*m+:32], a ^ 32'h5A5A_5A5A)
      @(negedge clk);
      m_req[m] = 1'b0;
      m_we[m] = 1'b0;
   end
   endtask
   task t_conc;
   begin
      slow = 4'h1;
      fork
         xfer(0, 32'h0000_0100, 4'h1);
         xfer(2, 32'hC000_0200, 4'h1);
         xfer(1, 32'h8000_0040, 4'h4);
      join
      `CHK(ord, 12'h102)
      arb_rr = 4'h1;
      xfer(0, 32'h0000_0300, 4'h1);
      ord = 12'h0;
      fork
         xfer(0, 32'h0000_0400, 4'h1);
         xfer(2, 32'h0000_0500, 4'h1);
      join
      `CHK(ord, 12'h020)
   end
   endtask
   task t_map;
      integer i;
      reg [447:0] ad;
   begin
      slow = 4'hA;
      ad = {32'h0000_0000, 32'h3FFF_FFFC, 32'h4000_0000, 32'h7FFF_FFFC, 32'h8000_3FFC, 32'h8000_4000,
         32'h9000_0000, 32'hBFFF_FFFC, 32'hC000_0000, 32'hDFFF_FFFC, 32'hE000_0000, 32'hEFFF_FFFC,
         32'hF000_0000, 32'hFC00_0010};
      for (i = 13; i >= 0; i = i - 1)
         xfer(0, ad[32*i+:32], 56'h11_2240_0011_0088 >> (4 * i));
      `CHK(modreg_offset, 32'h0000_0010)
      sram_base = 14'h0001;
      xfer(0, 32'h8000_4000, 4'h4);
   end
   endtask
   initial
   begin
      t_mode(1'b0);
      t_conc;
      t_map;
      t_mode(1'b1);
      give_verdict;
   end
endmodule
bind sbr_router sbr_router_checker CHKR (.clk, .rst_b, .m_req, .m_addr, .m_ack_r, .m_err_r, .s_req, .s_addr,
   .s_ack, .cs_port_size, .ext_port_size_eff, .ext_port_bad, .split_mode, .ext_lane_en, .sdram_lane_en,
   .modreg_offset);
